// >>> pkg/pme_pkg.sv
// constants and types shared by the programming mode entry block
package pme_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned ENTRY_TIME_NS  = 5200000;
  localparam int unsigned UART_BAUD      = 230400;
  localparam int unsigned CMD_W          = 16;
  // interface-enable command word; value is arbitrary
  localparam logic [15:0] IF_ENABLE_CMD  = 16'hc35a;
  localparam logic        APM_REQ_RESET  = 1'b0;
  localparam int unsigned UART_BITS      = 10;
  localparam int unsigned UART_STOP_IDX  = 9;

  function automatic int unsigned ceil_div(input int unsigned a, input int unsigned b);
    return (a + b - 1) / b;
  endfunction

  // least time: rounded up to whole cycles
  localparam int unsigned ENTRY_CYCLES   = ceil_div(ENTRY_TIME_NS, CLK_PERIOD_NS);
  localparam int unsigned UART_BIT_CYC   = CLK_HZ / UART_BAUD;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HOLD,
    ST_ISP_WAIT,
    ST_ISP_SPI,
    ST_ISP_UART,
    ST_APM
  } pme_state_t;

endpackage

// >>> rtl/pme_spi_cmd_det.sv
// serial-clock domain detector for the interface-enable command on the sync port
`timescale 1ns/1ps
`default_nettype none
module pme_spi_cmd_det #(
  parameter logic [15:0] CMD = 16'hc35a
) (
  input  wire logic spi_sck_i,
  input  wire logic clr_i,
  input  wire logic mosi_i,
  output logic      hit_o
);
  logic [15:0] shift_r;

  // clr_i comes from a clock_i register; it is this domain's reset since sck may be stopped
  always_ff @(posedge spi_sck_i or posedge clr_i) begin
    if (clr_i) begin
      shift_r <= 16'h0000;
    end else begin
      shift_r <= {shift_r[14:0], mosi_i};
    end
  end

  always_ff @(posedge spi_sck_i or posedge clr_i) begin
    if (clr_i) begin
      hit_o <= 1'b0;
    end else if ({shift_r[14:0], mosi_i} == CMD) begin
      hit_o <= 1'b1;
    end
  end

  a_hit_sticky: assert property (@(posedge spi_sck_i) disable iff (clr_i)
    hit_o |=> hit_o)
    else $error("command hit dropped while armed");

  a_hit_cause: assert property (@(posedge spi_sck_i) disable iff (clr_i)
    (!hit_o && {shift_r[14:0], mosi_i} == CMD) |=> hit_o)
    else $error("command word seen but no hit");
endmodule
`default_nettype wire

// >>> rtl/pme_top.sv
// programming mode entry: reset-hold detection, command wait and port pin control
//
// Contract
// - reset pin held low keeps the module in reset.
// - pin held low for the entry time enters the programming entry state.
// - programming stays off until an interface-enable command arrives.
// - in-system programming is the default mode after power-up.
// - requested auto mode is entered right after the next software reset, or a reset pin release before the entry time.
// - auto mode accepts firmware over sync serial, async serial or USB.
// - sync port data out drives only in programming mode, else pulled-up high impedance.
// - serial clock is a pulled-up input in reset, driven output when active.
// - async transmit drives only in programming mode, else high impedance.
// - USB lines serve programming in auto mode, else pulled-up high impedance.
`timescale 1ns/1ps
`default_nettype none
module pme_top
  import pme_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = pme_pkg::ENTRY_CYCLES,
  parameter int unsigned BIT_CYCLES  = pme_pkg::UART_BIT_CYC
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic reset_pin_n_i,
  input  wire logic auto_prog_req_i,
  input  wire logic sw_reset_i,
  input  wire logic prog_done_i,
  input  wire logic spi_sck_i,
  input  wire logic spi_mosi_i,
  input  wire logic uart_rx_i,
  input  wire logic prog_miso_i,
  input  wire logic prog_uart_tx_i,
  input  wire logic prog_usb_plus_line_i,
  input  wire logic prog_usb_minus_line_i,
  input  wire logic prog_usb_oe_i,
  input  wire logic master_sck_i,
  output logic      core_rst_o,
  output logic      in_system_prog_mode_o,
  output logic      auto_prog_mode_o,
  output logic      prog_spi_en_o,
  output logic      prog_uart_en_o,
  output logic      prog_usb_en_o,
  output logic      spi_sck_o,
  output logic      spi_sck_oe_o,
  output logic      spi_sck_pu_o,
  output logic      spi_miso_o,
  output logic      spi_miso_oe_o,
  output logic      spi_miso_pu_o,
  output logic      uart_tx_o,
  output logic      uart_tx_oe_o,
  output logic      usb_plus_line_o,
  output logic      usb_minus_line_o,
  output logic      usb_line_oe_o,
  output logic      usb_line_pu_o
);
  import pme_pkg::*;

  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned BW = $clog2(BIT_CYCLES + 1);

  initial begin
    if (HOLD_CYCLES < 1 || BIT_CYCLES < 4) begin
      $error("pme_top: HOLD_CYCLES must be >= 1 and BIT_CYCLES >= 4");
    end
  end

  pme_state_t  state_r;
  logic [HW-1:0] hold_cnt_r;
  logic        pin_q1_r, pin_s_r;
  logic        rx_q1_r, rx_s_r;
  logic        hit_q1_r, hit_s_r;
  logic        spi_clr_r;
  logic        spi_hit;
  logic        apm_req_r;
  logic        uart_busy_r;
  logic [3:0]  uart_idx_r;
  logic [BW-1:0] uart_cnt_r;
  logic [15:0] uart_sh_r;
  logic        uart_hit_r;
  logic        spi_prog, uart_prog, usb_prog;

  // pins are asynchronous: two flops before any use
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_q1_r <= 1'b1;
      pin_s_r  <= 1'b1;
      rx_q1_r  <= 1'b1;
      rx_s_r   <= 1'b1;
      hit_q1_r <= 1'b0;
      hit_s_r  <= 1'b0;
    end else begin
      pin_q1_r <= reset_pin_n_i;
      pin_s_r  <= pin_q1_r;
      rx_q1_r  <= uart_rx_i;
      rx_s_r   <= rx_q1_r;
      hit_q1_r <= spi_hit;
      hit_s_r  <= hit_q1_r;
    end
  end

  // detector armed only while waiting; clearing it also drops any stale hit
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      spi_clr_r <= 1'b1;
    end else begin
      spi_clr_r <= (state_r != ST_ISP_WAIT);
    end
  end

  pme_spi_cmd_det #(
    .CMD (IF_ENABLE_CMD)
  ) u_spi_det (
    .spi_sck_i (spi_sck_i),
    .clr_i     (spi_clr_r),
    .mosi_i    (spi_mosi_i),
    .hit_o     (spi_hit)
  );

  // application request latch; reset value selects in-system programming
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      apm_req_r <= APM_REQ_RESET;
    end else if (auto_prog_req_i) begin
      apm_req_r <= 1'b1; // request wins over a coincident done
    end else if (state_r == ST_APM && prog_done_i) begin
      apm_req_r <= 1'b0;
    end
  end

  // async receiver, 8N1 lsb first, only listening while waiting
  always_ff @(posedge clock_i) begin
    if (rst_i || state_r != ST_ISP_WAIT) begin
      uart_busy_r <= 1'b0;
      uart_idx_r  <= 4'h0;
      uart_cnt_r  <= '0;
      uart_sh_r   <= 16'h0000;
      uart_hit_r  <= 1'b0;
    end else if (!uart_busy_r) begin
      if (!rx_s_r) begin
        uart_busy_r <= 1'b1;
        uart_idx_r  <= 4'h0;
        uart_cnt_r  <= BW'(BIT_CYCLES / 2);
      end
    end else if (uart_cnt_r != '0) begin
      uart_cnt_r <= uart_cnt_r - 1'b1;
    end else begin
      uart_cnt_r <= BW'(BIT_CYCLES - 1);
      uart_idx_r <= uart_idx_r + 4'h1;
      if (uart_idx_r == 4'h0 && rx_s_r) begin
        uart_busy_r <= 1'b0; // glitch, not a start bit
      end else if (uart_idx_r == 4'(UART_STOP_IDX)) begin
        uart_busy_r <= 1'b0;
        if (!rx_s_r) begin
          uart_sh_r <= 16'h0000; // low stop: byte must not pair with the next one
        end else if (uart_sh_r == IF_ENABLE_CMD) begin
          uart_hit_r <= 1'b1;
        end
      end else if (uart_idx_r != 4'h0) begin
        uart_sh_r <= {uart_sh_r[15:8], rx_s_r, uart_sh_r[7:1]};
        if (uart_idx_r == 4'h1) begin
          uart_sh_r <= {uart_sh_r[7:0], rx_s_r, uart_sh_r[7:1]};
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hold_cnt_r <= '0;
    end else if (state_r == ST_HOLD && !pin_s_r) begin
      hold_cnt_r <= hold_cnt_r + 1'b1;
    end else begin
      hold_cnt_r <= '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (!pin_s_r) begin
            state_r <= ST_HOLD;
          end else if (sw_reset_i && apm_req_r) begin
            state_r <= ST_APM;
          end
        end
        ST_HOLD: begin
          if (!pin_s_r && hold_cnt_r == HW'(HOLD_CYCLES - 1)) begin
            state_r <= ST_ISP_WAIT;
          end else if (pin_s_r) begin
            state_r <= apm_req_r ? ST_APM : ST_RUN;
          end
        end
        ST_ISP_WAIT: begin
          if (hit_s_r) begin
            state_r <= ST_ISP_SPI;
          end else if (uart_hit_r) begin
            state_r <= ST_ISP_UART;
          end
        end
        ST_ISP_SPI, ST_ISP_UART, ST_APM: begin
          if (prog_done_i) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  assign spi_prog  = (state_r == ST_ISP_SPI) || (state_r == ST_APM);
  assign uart_prog = (state_r == ST_ISP_UART) || (state_r == ST_APM);
  assign usb_prog  = (state_r == ST_APM);

  assign core_rst_o            = (state_r != ST_RUN);
  assign in_system_prog_mode_o = (state_r == ST_ISP_SPI) || (state_r == ST_ISP_UART);
  assign auto_prog_mode_o      = (state_r == ST_APM);
  assign prog_spi_en_o         = spi_prog;
  assign prog_uart_en_o        = uart_prog;
  assign prog_usb_en_o         = usb_prog;
  assign spi_sck_oe_o          = !core_rst_o;
  assign spi_sck_pu_o          = core_rst_o;
  assign spi_miso_oe_o         = spi_prog;
  assign spi_miso_pu_o         = !spi_prog;
  assign uart_tx_oe_o          = uart_prog;
  assign usb_line_oe_o         = usb_prog && prog_usb_oe_i;
  assign usb_line_pu_o         = !usb_prog;

  // pin data registered to keep glitches off the pads
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      spi_sck_o        <= 1'b0;
      spi_miso_o       <= 1'b1;
      uart_tx_o        <= 1'b1;
      usb_plus_line_o  <= 1'b0;
      usb_minus_line_o <= 1'b0;
    end else begin
      spi_sck_o        <= master_sck_i;
      spi_miso_o       <= prog_miso_i;
      uart_tx_o        <= prog_uart_tx_i;
      usb_plus_line_o  <= prog_usb_plus_line_i;
      usb_minus_line_o <= prog_usb_minus_line_i;
    end
  end

  sequence s_held_to_entry;
    state_r == ST_HOLD && !pin_s_r && hold_cnt_r == HW'(HOLD_CYCLES - 1);
  endsequence

  a_pin_low_reset: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_r == ST_RUN && !pin_s_r) |=> core_rst_o && state_r == ST_HOLD)
    else $error("reset pin low did not reset the module");
  a_entry_after_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    s_held_to_entry |=> state_r == ST_ISP_WAIT ##1 core_rst_o)
    else $error("entry time reached without entering wait state");
  a_no_isp_wo_cmd: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_r == ST_ISP_WAIT && !hit_s_r && !uart_hit_r) |=> !in_system_prog_mode_o)
    else $error("programming started without command");
  a_default_isp: assert property (@(posedge clock_i)
    rst_i |=> !apm_req_r && !auto_prog_mode_o)
    else $error("auto mode selected after power-up");
  a_apm_on_reset: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_r == ST_RUN && pin_s_r && sw_reset_i && apm_req_r) |=> auto_prog_mode_o)
    else $error("auto mode not entered after software reset");
  a_apm_paths: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(auto_prog_mode_o) |-> prog_spi_en_o && prog_uart_en_o && prog_usb_en_o)
    else $error("auto mode missing a firmware path");
  a_spi_switch: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_r == ST_ISP_WAIT && hit_s_r) |=> spi_miso_oe_o && !uart_tx_oe_o)
    else $error("sync port not switched on command");
  a_miso_hiz: assert property (@(posedge clock_i) disable iff (rst_i)
    (core_rst_o && !prog_spi_en_o) |-> !spi_miso_oe_o && spi_miso_pu_o)
    else $error("data out driven outside programming");
  a_sck_dir: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(core_rst_o) |-> spi_sck_oe_o && !$past(spi_sck_oe_o))
    else $error("serial clock direction wrong");
  a_uart_switch: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_r == ST_ISP_WAIT && uart_hit_r && !hit_s_r) |=> uart_tx_oe_o && !spi_miso_oe_o)
    else $error("async port not switched on command");
  a_tx_hiz: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_r == ST_ISP_WAIT) |-> !uart_tx_oe_o)
    else $error("async transmit driven while waiting");
  a_usb_hiz: assert property (@(posedge clock_i) disable iff (rst_i)
    !auto_prog_mode_o |-> !usb_line_oe_o && usb_line_pu_o)
    else $error("usb lines driven outside auto mode");
  a_early_release: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_r == ST_HOLD && pin_s_r && !apm_req_r) |=> !core_rst_o)
    else $error("early release did not resume normal operation");
endmodule
`default_nettype wire

// >>> verif/pme_host_model.sv
// host programmer model: reset pin, sync and async serial drive
`timescale 1ns/1ps
`default_nettype none
module pme_host_model #(
  parameter int unsigned BIT_CYC = 8
) (
  input  wire logic clock_i,
  output logic      reset_pin_n_o,
  output logic      spi_sck_o,
  output logic      spi_mosi_o,
  output logic      uart_rx_o
);
  initial begin
    reset_pin_n_o = 1'b1;
    spi_sck_o     = 1'b1; // released: pulled up until the first frame
    spi_mosi_o    = 1'b1;
    uart_rx_o     = 1'b1;
  end
  task automatic hold_pin(input int unsigned cycles);
    @(posedge clock_i) reset_pin_n_o <= 1'b0;
    repeat (cycles) @(posedge clock_i);
    reset_pin_n_o <= 1'b1;
  endtask
  // msb first, sampled on the rising edge; clock idles at its pull-up level
  // between frames, so no stray rising edge shifts an extra bit
  task automatic send_spi(input logic [15:0] word);
    #3;
    for (int i = 15; i >= 0; i--) begin
      spi_sck_o  = 1'b0;
      spi_mosi_o = word[i];
      #16 spi_sck_o = 1'b1;
      #16;
    end
    spi_mosi_o = ~word[0];
  endtask
  task automatic send_uart(input logic [7:0] data, input logic stop);
    logic [9:0] frame;
    frame = {stop, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_i) uart_rx_o <= frame[i];
      repeat (BIT_CYC - 1) @(posedge clock_i);
    end
    @(posedge clock_i) uart_rx_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verif/programming_mode_entry_tb.sv
// self-checking bench for the programming mode entry block
`timescale 1ns/1ps
`default_nettype none
module programming_mode_entry_tb;
  import pme_pkg::*;
  localparam int unsigned HOLD = 20;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        req     = 1'b0;
  logic        swr     = 1'b0;
  logic        done    = 1'b0;
  logic        pmiso   = 1'b1;
  logic        ptx     = 1'b1;
  logic        pdp     = 1'b0;
  logic        pdm     = 1'b0;
  logic        poe     = 1'b0;
  logic        msck    = 1'b0;
  logic [31:0] rng     = 32'h0000b98a;
  wire logic   pin_n, sck, mosi, rx;
  logic        core, in_system_prog_mode, auto_prog_mode, sen, uen, ben, sck_oe, sck_pu;
  logic        miso_oe, miso_pu, tx_oe, usb_oe, usb_pu;
  logic [9:0]  seen, prev;
  logic [15:0] word;
  logic [9:0]  exp_q[$];
  wire logic [4:0] dat_o;
  logic [4:0]  dat_q   = 5'h00;
  logic        rst_d   = 1'b1;
  int          miscompares  = 0;
  int          total_checks = 0;

  always #12.5 clock_i = ~clock_i;
  assign seen = {core, in_system_prog_mode, auto_prog_mode, sen, uen, ben, miso_oe, tx_oe, usb_pu, sck_oe};

  pme_host_model #(.BIT_CYC(8)) host_u (.clock_i(clock_i), .reset_pin_n_o(pin_n),
    .spi_sck_o(sck), .spi_mosi_o(mosi), .uart_rx_o(rx));

  pme_top #(.HOLD_CYCLES(HOLD), .BIT_CYCLES(8)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .reset_pin_n_i(pin_n), .auto_prog_req_i(req),
    .sw_reset_i(swr), .prog_done_i(done), .spi_sck_i(sck), .spi_mosi_i(mosi),
    .uart_rx_i(rx), .prog_miso_i(pmiso), .prog_uart_tx_i(ptx), .prog_usb_plus_line_i(pdp),
    .prog_usb_minus_line_i(pdm), .prog_usb_oe_i(poe), .master_sck_i(msck), .core_rst_o(core),
    .in_system_prog_mode_o(in_system_prog_mode), .auto_prog_mode_o(auto_prog_mode), .prog_spi_en_o(sen),
    .prog_uart_en_o(uen), .prog_usb_en_o(ben), .spi_sck_o(dat_o[4]), .spi_sck_oe_o(sck_oe),
    .spi_sck_pu_o(sck_pu), .spi_miso_o(dat_o[3]), .spi_miso_oe_o(miso_oe),
    .spi_miso_pu_o(miso_pu), .uart_tx_o(dat_o[2]), .uart_tx_oe_o(tx_oe),
    .usb_plus_line_o(dat_o[1]), .usb_minus_line_o(dat_o[0]), .usb_line_oe_o(usb_oe),
    .usb_line_pu_o(usb_pu));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // expected pin and enable picture for each mode
  function automatic logic [9:0] vec(input pme_state_t s);
    logic c, a, sp, ua;
    c  = (s != ST_RUN);
    a  = (s == ST_APM);
    sp = (s == ST_ISP_SPI);
    ua = (s == ST_ISP_UART);
    return {c, sp | ua, a, sp | a, ua | a, a, sp | a, ua | a, ~a, ~c};
  endfunction

  task automatic check(input string name, input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic pulse(input int k);
    @(posedge clock_i);
    case (k)
      0: req <= 1'b1;
      1: swr <= 1'b1;
      default: done <= 1'b1;
    endcase
    @(posedge clock_i);
    {req, swr, done} <= 3'b000;
  endtask

  // bounded wait for every queued mode change to show up
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("unexpected timeout: expected 0 pending seen %0d", exp_q.size());
      print_verdict();
    end
    repeat (4) @(posedge clock_i);
  endtask

  // random programming-unit data keeps the pin data paths toggling
  always @(posedge clock_i) begin
    rng <= xs(rng);
    {pmiso, ptx, pdp, pdm, poe, msck} <= rng[5:0];
  end

  // any unannounced mode change is compared against the old picture and fails
  always @(posedge clock_i) begin
    #1;
    if (!rst_i && seen !== prev) begin
      if (exp_q.size() == 0) check("mode", seen, prev);
      else check("mode", seen, exp_q.pop_front());
    end
    if (!rst_i) check("pulls", {7'h00, miso_pu, sck_pu, usb_oe},
                      {7'h00, ~miso_oe, core, auto_prog_mode & poe});
    // pin data lags its source by one flop
    if (!rst_i && !rst_d) check("pin data", {5'h00, dat_o}, {5'h00, dat_q});
    dat_q = {msck, pmiso, ptx, pdp, pdm};
    rst_d = rst_i;
    prev = seen;
  end

  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    pulse(1);
    repeat (6) @(posedge clock_i);
    #1;
    check("default", seen, vec(ST_RUN));
    exp_q.push_back(vec(ST_HOLD));
    exp_q.push_back(vec(ST_RUN));
    host_u.hold_pin(HOLD / 2);
    drain();
    exp_q.push_back(vec(ST_HOLD));
    host_u.hold_pin(2 * HOLD);
    repeat (4) @(posedge clock_i);
    word = (rng[15:0] == IF_ENABLE_CMD) ? ~rng[15:0] : rng[15:0];
    host_u.send_spi(word);
    repeat (10) @(posedge clock_i);
    #1;
    check("wait", seen, vec(ST_ISP_WAIT));
    exp_q.push_back(vec(ST_ISP_SPI));
    host_u.send_spi(IF_ENABLE_CMD);
    drain();
    exp_q.push_back(vec(ST_RUN));
    pulse(2);
    drain();
    // a full hold beats a pending auto request
    pulse(0);
    exp_q.push_back(vec(ST_HOLD));
    host_u.hold_pin(2 * HOLD);
    host_u.send_uart(IF_ENABLE_CMD[15:8], 1'b0);
    repeat (16) @(posedge clock_i);
    host_u.send_uart(IF_ENABLE_CMD[7:0], 1'b1);
    repeat (20) @(posedge clock_i);
    exp_q.push_back(vec(ST_ISP_UART));
    host_u.send_uart(IF_ENABLE_CMD[15:8], 1'b1);
    host_u.send_uart(IF_ENABLE_CMD[7:0], 1'b1);
    drain();
    exp_q.push_back(vec(ST_RUN));
    pulse(2);
    drain();
    // the request made before the full hold is still pending
    exp_q.push_back(vec(ST_APM));
    pulse(1);
    drain();
    exp_q.push_back(vec(ST_RUN));
    pulse(2);
    drain();
    pulse(1);
    repeat (6) @(posedge clock_i);
    exp_q.push_back(vec(ST_APM));
    pulse(0);
    pulse(1);
    drain();
    exp_q.push_back(vec(ST_RUN));
    pulse(2);
    drain();
    exp_q.push_back(vec(ST_HOLD));
    exp_q.push_back(vec(ST_APM));
    pulse(0);
    host_u.hold_pin(HOLD / 4);
    drain();
    exp_q.push_back(vec(ST_RUN));
    pulse(2);
    drain();
    print_verdict();
  end
endmodule
`default_nettype wire
